// ### src/sync_fifo_pkg.sv
// Shared constants and carrier types for the sync, FIFO alignment and datapath control bank.
// Assumes an 8-bit register port driven by a serial control port engine on core_clk.
`default_nettype none

package sync_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] SYNC_CTRL_OFS      = 8'h10;  // Enable, rate, edge, averaging
  localparam logic [7:0] SYNC_PHASE_REQ_OFS = 8'h11;  // Requested phase after sync
  localparam logic [7:0] SYNC_FLAGS_OFS     = 8'h12;  // Lost and locked flags
  localparam logic [7:0] SYNC_READBACK_OFS  = 8'h13;  // Averaged phase, 6.2 format
  localparam logic [7:0] FIFO_OFS_CTRL_OFS  = 8'h17;  // Pointer phase offset
  localparam logic [7:0] FIFO_STATUS_OFS    = 8'h18;  // Warnings and alignment
  localparam logic [7:0] FIFO_LEVEL_OFS     = 8'h19;  // Thermometer fill level
  localparam logic [7:0] PATH_CTRL_OFS      = 8'h1B;  // Bypass and gain options

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int SYNC_EN_BIT      = 7;
  localparam int SYNC_RATE_BIT    = 6;
  localparam int SYNC_RISE_BIT    = 3;
  localparam int SYNC_LOST_BIT    = 7;
  localparam int SYNC_LOCKED_BIT  = 6;
  localparam int FIFO_WARN1_BIT   = 7;
  localparam int FIFO_WARN2_BIT   = 6;
  localparam int FIFO_ACK_BIT     = 2;
  localparam int FIFO_REQ_BIT     = 1;
  localparam int FIFO_HW_BIT      = 0;
  localparam int PATH_PREMOD_BIT  = 7;
  localparam int PATH_SINC_BIT    = 6;
  localparam int PATH_NCO_BIT     = 5;
  localparam int PATH_GAIN_BIT    = 3;
  localparam int PATH_PHDC_BIT    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Writable masks and reset values
  localparam logic [7:0] SYNC_CTRL_MASK   = 8'hCF;
  localparam logic [7:0] SYNC_CTRL_RST    = 8'h48;
  localparam logic [5:0] PHASE_REQ_RST    = 6'h00;
  localparam logic [2:0] FIFO_OFS_RST     = 3'h4;
  localparam logic [7:0] READBACK_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic bypass_premod;    // Quarter-rate premodulator skipped
    logic bypass_inv_sinc;  // Inverse sinc filter skipped
    logic bypass_nco;       // NCO skipped
    logic nco_half_gain;    // NCO input scaled by one half
    logic bypass_phase_dc;  // Phase compensation and dc offset skipped
  } path_ctrl_t;

  localparam path_ctrl_t PATH_CTRL_RST = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

  typedef struct packed {
    logic [2:0] wr_ptr;  // FIFO write pointer
    logic [2:0] rd_ptr;  // FIFO read pointer
  } fifo_ptr_t;

  typedef struct packed {
    logic       warn1;       // Pointers within one
    logic       warn2;       // Pointers within two
    logic       hw_aligned;  // Aligned after hardware reset
    logic       soft_done;   // One-cycle pulse, soft alignment finished
    logic [7:0] level;       // Thermometer fill level
  } fifo_stat_t;

endpackage : sync_fifo_pkg

`default_nettype wire

// ### src/fifo_ptr_align.sv
// FIFO pointer pair with alignment on hardware reset and on soft request.
// Assumes pointer advance strobes come from logic on core_clk.
`timescale 1ns/10ps
`default_nettype none

module fifo_ptr_align (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire logic                    wr_adv,
  input  wire logic                    rd_adv,
  input  wire logic [2:0]              phase_ofs,
  input  wire logic                    soft_req,
  output var  sync_fifo_pkg::fifo_ptr_t ptrs,
  output var  sync_fifo_pkg::fifo_stat_t stat
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    sync_fifo_pkg::fifo_ptr_t  ptrs;     // Pointer pair
    sync_fifo_pkg::fifo_stat_t stat;     // Flags and level
    logic                      hw_pend;  // Alignment after reset still due
  } align_state_t;

  align_state_t state_reg;   // Registered state
  align_state_t state_next;  // Next state
  logic [2:0]   diff_next;   // Write minus read, modulo 8
  logic [7:0]   therm_next;  // Level as thermometer

  // One level bit per position
  for (genvar i = 0; i < 8; i++) begin : g_therm
    assign therm_next[i] = (diff_next > 3'(i));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.stat.soft_done = 1'b0;
    // Pointers advance unless an alignment overrides the writer
    state_next.ptrs.rd_ptr = state_reg.ptrs.rd_ptr + 3'(rd_adv);
    state_next.ptrs.wr_ptr = state_reg.ptrs.wr_ptr + 3'(wr_adv);
    if (state_reg.hw_pend || soft_req) begin
      // Writer placed at the offset ahead of the reader
      state_next.ptrs.wr_ptr = state_next.ptrs.rd_ptr + phase_ofs;
      state_next.hw_pend = 1'b0;
      if (state_reg.hw_pend) begin
        state_next.stat.hw_aligned = 1'b1;
      end
      if (soft_req) begin
        state_next.stat.soft_done = 1'b1;
      end
    end
    diff_next = state_next.ptrs.wr_ptr - state_next.ptrs.rd_ptr;
    // Near-collision warnings, wrap counted both ways
    state_next.stat.warn1 = (diff_next == 3'h0) || (diff_next == 3'h1) || (diff_next == 3'h7);
    state_next.stat.warn2 = state_next.stat.warn1 || (diff_next == 3'h2) || (diff_next == 3'h6);
    state_next.stat.level = therm_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '{ptrs: '0, stat: '0, hw_pend: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ptrs = state_reg.ptrs;
  assign stat = state_reg.stat;

endmodule : fifo_ptr_align

`default_nettype wire

// ### src/sync_fifo_datapath_ctrl.sv
// Register bank for multichip sync, FIFO pointer alignment and datapath options.
// Assumes the serial port engine presents one-cycle register writes on core_clk,
// and that core_clk stands for the converter_sample_clock.
//
// Operation
// - Average 1 to 128 sync samples, 3-bit code
// - Sync measurement and frame_start run only while enabled
// - Apply requested 0-63 cycle phase after sync
// - Lost flag in bit 7 after lock lost
// - Locked flag in bit 6 once locked
// - Report averaged phase, 8-bit 6.2 format
// - FIFO reset puts writer offset ahead, default 4
// - Warning bit 7 when pointers within one
// - Warning bit 6 when pointers within two
// - Writing status bit 1 realigns pointers
// - Bit 2 acknowledges soft alignment done
// - Bit 0 set after hardware reset alignment
// - FIFO level as 8-bit thermometer code
// - Bits 7,6,5 bypass premod, sinc, NCO
// - Bit 3 halves NCO input to modulator
// - Bit 2 bypasses phase and dc stage
`timescale 1ns/10ps
`default_nettype none

module sync_fifo_datapath_ctrl (
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      reg_wr,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output var  logic [7:0]                reg_rdata,
  input  wire logic                      sync_in,
  input  wire logic                      fifo_wr_adv,
  input  wire logic                      fifo_rd_adv,
  input  wire logic signed [15:0]        nco_in,
  output var  logic signed [15:0]        nco_scaled,
  output var  logic                      frame_start,
  output var  sync_fifo_pkg::path_ctrl_t path_ctrl,
  output var  sync_fifo_pkg::fifo_ptr_t  fifo_ptrs
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]                sync_ctrl;   // Enable, rate, edge, averaging
    logic [5:0]                phase_req;   // Requested phase after sync
    logic [2:0]                fifo_ofs;    // Pointer phase offset
    sync_fifo_pkg::path_ctrl_t path;        // Bypass and gain options
    logic                      soft_pend;   // Soft alignment requested, not done
    logic                      soft_go;     // One-cycle request to the aligner
    logic                      soft_ack;    // Soft alignment acknowledged
    logic                      sync_meta;   // First synchroniser stage
    logic                      sync_lvl;    // Second synchroniser stage
    logic                      sync_prev;   // Previous synchronised level
    logic [5:0]                frame_cnt;   // Output frame phase
    logic [7:0]                avg_cnt;     // Samples taken this round
    logic [12:0]               acc;         // Sum of sampled phases
    logic [7:0]                readback;    // Averaged phase, 6.2
    logic                      locked;      // Sync attained
    logic                      lost;        // Sync attained, then lost
    logic                      frame_start; // Frame boundary pulse
    logic signed [15:0]        nco_scaled;  // Scaled NCO sample
    logic [7:0]                rdata;       // Read data
  } ctrl_state_t;

  ctrl_state_t               state_reg;   // Registered state
  ctrl_state_t               state_next;  // Next state
  sync_fifo_pkg::fifo_stat_t fstat;       // Aligner flags
  sync_fifo_pkg::fifo_ptr_t  fptrs;       // Aligner pointers

  // Combinational helpers, given values at the top of the process
  logic        sync_en;     // Sync logic enabled
  logic        sync_edge;   // Chosen edge of the sync input
  logic [5:0]  sample;      // Phase taken at this edge
  logic [12:0] acc_sum;     // Sum including this sample
  logic [7:0]  avg_need;    // Samples per average
  logic [14:0] avg_scaled;  // Sum in quarter cycles after divide by the sample count
  logic [7:0]  avg_val;     // Averaged phase, 6.2
  logic        wr_hit;      // Register write strobe for decode

  ////////////////////////////////////////////////////////////////////////////
  // Pointer aligner
  fifo_ptr_align u_align (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .wr_adv    (fifo_wr_adv),
    .rd_adv    (fifo_rd_adv),
    .phase_ofs (state_reg.fifo_ofs),
    .soft_req  (state_reg.soft_go),
    .ptrs      (fptrs),
    .stat      (fstat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    sync_en    = state_reg.sync_ctrl[sync_fifo_pkg::SYNC_EN_BIT];
    sample     = '0;
    acc_sum    = '0;
    avg_scaled = '0;
    avg_val    = '0;
    wr_hit     = reg_wr;
    avg_need   = 8'h01 << state_reg.sync_ctrl[2:0];

    // Sync pin through two flops before any use
    state_next.sync_meta = sync_in;
    state_next.sync_lvl  = state_reg.sync_meta;
    state_next.sync_prev = state_reg.sync_lvl;
    sync_edge = state_reg.sync_ctrl[sync_fifo_pkg::SYNC_RISE_BIT]
              ? (state_reg.sync_lvl && !state_reg.sync_prev)
              : (!state_reg.sync_lvl && state_reg.sync_prev);

    // Frame phase runs freely between sync edges
    state_next.frame_cnt   = state_reg.frame_cnt + 6'h01;
    state_next.frame_start = sync_en && (state_reg.frame_cnt == 6'h3F);

    if (!sync_en) begin
      // Disabled: no measurement, no flags
      state_next.locked  = 1'b0;
      state_next.lost    = 1'b0;
      state_next.acc     = '0;
      state_next.avg_cnt = '0;
    end else if (sync_edge) begin
      // Unlocked edges re-seat the frame at the requested phase
      if (!state_reg.locked) begin
        state_next.frame_cnt = state_reg.phase_req + 6'h01;
        sample = state_reg.phase_req;
      end else begin
        sample = state_reg.frame_cnt;
      end
      acc_sum = state_reg.acc + 13'(sample);
      if (state_reg.avg_cnt + 8'h01 == avg_need) begin
        // Average in quarter cycles; shift keeps the fraction
        avg_scaled = {acc_sum, 2'b00} >> state_reg.sync_ctrl[2:0];
        avg_val    = avg_scaled[7:0];
        state_next.readback = avg_val;
        state_next.acc      = '0;
        state_next.avg_cnt  = '0;
        if (avg_val == {state_reg.phase_req, 2'b00}) begin
          state_next.locked = 1'b1;
        end else begin
          state_next.locked = 1'b0;
          if (state_reg.locked) begin
            state_next.lost = 1'b1;
          end
        end
      end else begin
        state_next.acc     = acc_sum;
        state_next.avg_cnt = state_reg.avg_cnt + 8'h01;
      end
    end

    // Soft alignment handshake; completion outranks a clear
    state_next.soft_go = 1'b0;
    if (wr_hit && reg_addr == sync_fifo_pkg::FIFO_STATUS_OFS
        && reg_wdata[sync_fifo_pkg::FIFO_REQ_BIT]) begin
      state_next.soft_pend = 1'b1;
      state_next.soft_go   = 1'b1;
      state_next.soft_ack  = 1'b0;
    end
    if (fstat.soft_done) begin
      state_next.soft_pend = 1'b0;
      state_next.soft_ack  = 1'b1;
    end

    // Writes reach only the writable fields
    if (wr_hit) begin
      unique case (reg_addr)
        sync_fifo_pkg::SYNC_CTRL_OFS: begin
          state_next.sync_ctrl = reg_wdata & sync_fifo_pkg::SYNC_CTRL_MASK;
          // Restart averaging, so a shorter length never strands the sample count
          state_next.acc       = '0;
          state_next.avg_cnt   = '0;
        end
        sync_fifo_pkg::SYNC_PHASE_REQ_OFS: begin
          state_next.phase_req = reg_wdata[5:0];
        end
        sync_fifo_pkg::FIFO_OFS_CTRL_OFS: begin
          state_next.fifo_ofs = reg_wdata[2:0];
        end
        sync_fifo_pkg::PATH_CTRL_OFS: begin
          state_next.path.bypass_premod   = reg_wdata[sync_fifo_pkg::PATH_PREMOD_BIT];
          state_next.path.bypass_inv_sinc = reg_wdata[sync_fifo_pkg::PATH_SINC_BIT];
          state_next.path.bypass_nco      = reg_wdata[sync_fifo_pkg::PATH_NCO_BIT];
          state_next.path.nco_half_gain   = reg_wdata[sync_fifo_pkg::PATH_GAIN_BIT];
          state_next.path.bypass_phase_dc = reg_wdata[sync_fifo_pkg::PATH_PHDC_BIT];
        end
        default: begin
          // Status addresses and unmapped space take no write
          state_next.rdata = state_next.rdata;
        end
      endcase
    end

    // NCO input to the modulator, halved on request
    state_next.nco_scaled = state_reg.path.nco_half_gain ? (nco_in >>> 1) : nco_in;

    // Read data, one cycle after the address
    unique case (reg_addr)
      sync_fifo_pkg::SYNC_CTRL_OFS:      state_next.rdata = state_reg.sync_ctrl;
      sync_fifo_pkg::SYNC_PHASE_REQ_OFS: state_next.rdata = {2'b00, state_reg.phase_req};
      sync_fifo_pkg::SYNC_FLAGS_OFS:     state_next.rdata = {state_reg.lost, state_reg.locked, 6'h00};
      sync_fifo_pkg::SYNC_READBACK_OFS:  state_next.rdata = state_reg.readback;
      sync_fifo_pkg::FIFO_OFS_CTRL_OFS:  state_next.rdata = {5'h00, state_reg.fifo_ofs};
      sync_fifo_pkg::FIFO_STATUS_OFS:    state_next.rdata = {fstat.warn1, fstat.warn2, 3'h0, state_reg.soft_ack,
                                                             state_reg.soft_pend, fstat.hw_aligned};
      sync_fifo_pkg::FIFO_LEVEL_OFS:     state_next.rdata = fstat.level;
      sync_fifo_pkg::PATH_CTRL_OFS:      state_next.rdata = {state_reg.path.bypass_premod,
                                                             state_reg.path.bypass_inv_sinc,
                                                             state_reg.path.bypass_nco, 1'b0,
                                                             state_reg.path.nco_half_gain,
                                                             state_reg.path.bypass_phase_dc, 2'b00};
      default:                           state_next.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg           <= '0;
      state_reg.sync_ctrl <= sync_fifo_pkg::SYNC_CTRL_RST;
      state_reg.phase_req <= sync_fifo_pkg::PHASE_REQ_RST;
      state_reg.fifo_ofs  <= sync_fifo_pkg::FIFO_OFS_RST;
      state_reg.path      <= sync_fifo_pkg::PATH_CTRL_RST;
      state_reg.readback  <= sync_fifo_pkg::READBACK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata   = state_reg.rdata;
  assign nco_scaled  = state_reg.nco_scaled;
  assign frame_start = state_reg.frame_start;
  assign path_ctrl   = state_reg.path;
  assign fifo_ptrs   = fptrs;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sync_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !state_reg.sync_ctrl[sync_fifo_pkg::SYNC_EN_BIT] |=> !state_reg.locked && !state_reg.lost)
    else $error("sync flags active while disabled");

  avg_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg.avg_cnt < (8'h01 << state_reg.sync_ctrl[2:0]))
    else $error("sample count beyond averaging length");

  frame_seat_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sync_en && sync_edge && !state_reg.locked && !wr_hit
    |=> state_reg.frame_cnt == $past(state_reg.phase_req) + 6'h01)
    else $error("frame not seated at requested phase");

  lost_cause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(state_reg.lost) |-> $past(state_reg.locked) && !state_reg.locked)
    else $error("lost flag without prior lock");

  lock_match_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(state_reg.locked) |-> state_reg.readback[1:0] == 2'b00)
    else $error("lock on fractional phase");

  ptr_offset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg.soft_go |=> (fptrs.wr_ptr - fptrs.rd_ptr) == $past(state_reg.fifo_ofs))
    else $error("pointer offset wrong after alignment");

  warn_near_a: assert property (@(posedge core_clk) disable iff (!nrst)
    fstat.warn1 |-> fstat.warn2)
    else $error("warning one without warning two");

  soft_ack_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg.soft_go |-> ##[1:2] state_reg.soft_ack)
    else $error("soft alignment not acknowledged");

  hw_align_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(nrst) |-> fstat.hw_aligned)
    else $error("no alignment after hardware reset");

  level_therm_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $countones(fstat.level) == 32'(3'(fptrs.wr_ptr - fptrs.rd_ptr)))
    else $error("level does not match pointers");

  nco_half_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg.path.nco_half_gain && $stable(state_reg.path) |=> nco_scaled == ($past(nco_in) >>> 1))
    else $error("NCO input not halved");

  ro_ignore_a: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr == sync_fifo_pkg::SYNC_READBACK_OFS && !sync_edge |=> $stable(state_reg.readback))
    else $error("read-only readback changed by write");

endmodule : sync_fifo_datapath_ctrl

`default_nettype wire

// ### test/host_port_model.sv
// Host controller model for the register port of the sync and FIFO control bank.
// Assumes the bench calls its tasks; inputs change only at falling core_clk edges.
`timescale 1ns/10ps
`default_nettype none

module host_port_model (
  input  wire logic       core_clk,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write strobe; data turned over after release so it is never stale
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // Address taken at edge N, data shown after edge N, read after edge N+1
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    repeat (2) @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  // Host keeps the pointer offset at its nominal setting
  task automatic set_nominal();
    wr(8'h17, 8'h04);
  endtask : set_nominal
endmodule : host_port_model

`default_nettype wire

// ### test/sync_fifo_datapath_ctrl_tb_top.sv
// Self-checking bench for the sync, FIFO alignment and datapath control bank.
// Assumes the host model drives the register port; bench drives the far side.
`timescale 1ns/10ps
`default_nettype none

module sync_fifo_datapath_ctrl_tb_top;
  logic                       core_clk = 1'b0;   // 250 MHz clock
  logic                       nrst     = 1'b0;   // Held low at start
  logic                       sync_in  = 1'b0;   // Sync pin
  logic                       fifo_wr_adv = 1'b0, fifo_rd_adv = 1'b0;
  logic                       reg_wr;
  logic [7:0]                 reg_addr, reg_wdata, reg_rdata, rv;
  logic signed [15:0]         nco_in = 16'sh0000, nco_scaled;
  logic                       frame_start;
  sync_fifo_pkg::path_ctrl_t  path_ctrl;
  sync_fifo_pkg::fifo_ptr_t   fifo_ptrs;
  int                         errors = 0, num_checks = 0, i, k;

  always #2 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Instances
  host_port_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
                        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  sync_fifo_datapath_ctrl uut (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_in(sync_in), .fifo_wr_adv(fifo_wr_adv),
    .fifo_rd_adv(fifo_rd_adv), .nco_in(nco_in), .nco_scaled(nco_scaled), .frame_start(frame_start),
    .path_ctrl(path_ctrl), .fifo_ptrs(fifo_ptrs));

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  task automatic end_sim();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    check(16'(rv), 16'(exp));
  endtask : rchk

  // Bounded poll; a timeout counts and closes the run
  task automatic poll(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    for (k = 0; k < 40 && rv !== exp; k++) host.rd(a, rv);
    check(16'(rv), 16'(exp));
    if (rv !== exp) end_sim();
  endtask : poll

  // Sync pulse of four cycles, then a gap
  task automatic pulse(input int gap);
    @(negedge core_clk);
    sync_in = 1'b1;
    repeat (4) @(negedge core_clk);
    sync_in = 1'b0;
    repeat (gap) @(negedge core_clk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    fifo_wr_adv = 1'b1;  // Both pointers run, so their distance holds
    fifo_rd_adv = 1'b1;
    rchk(8'h11, 8'h00);
    rchk(8'h13, 8'h00);
    rchk(8'h17, 8'h04);
    rchk(8'h1B, 8'hE4);
    rchk(8'h12, 8'h00);
    rchk(8'h18, 8'h01);
    rchk(8'h19, 8'h0F);
    rchk(8'h20, 8'h00);
    // Datapath options and NCO scaling
    host.wr(8'h1B, 8'h08);
    check(16'(path_ctrl), 16'h0002);
    nco_in = -16'sd3;
    @(negedge core_clk);
    check(nco_scaled, 16'hFFFE);
    host.wr(8'h1B, 8'h04);
    check(16'(path_ctrl), 16'h0001);
    @(negedge core_clk);
    check(nco_scaled, 16'hFFFD);
    // Writes to read-only places leave them alone
    host.wr(8'h12, 8'hFF);
    host.wr(8'h13, 8'hFF);
    host.wr(8'h19, 8'hFF);
    rchk(8'h12, 8'h00);
    rchk(8'h13, 8'h00);
    rchk(8'h19, 8'h0F);
    // Soft alignment at every pointer offset
    for (i = 0; i < 8; i++) begin
      host.wr(8'h17, 8'(i));
      host.wr(8'h18, 8'h02);
      poll(8'h18, {(i inside {0, 1, 7}), (i inside {0, 1, 2, 6, 7}), 6'h05});
      rchk(8'h19, 8'((1 << i) - 1));
      check(16'(3'(fifo_ptrs.wr_ptr - fifo_ptrs.rd_ptr)), 16'(i));
    end
    host.set_nominal();
    // Sync: two-sample average, phase request 5
    host.wr(8'h11, 8'h05);
    host.wr(8'h10, 8'h89);
    pulse(0);
    // First frame boundary: frame seated at phase 6, then 57 more cycles to the wrap
    for (k = 0; k < 70 && frame_start !== 1'b1; k++) @(negedge core_clk);
    check(16'(k), 16'h0039);
    rchk(8'h12, 8'h00);
    pulse(10);
    poll(8'h12, 8'h40);
    rchk(8'h13, 8'h14);
    pulse(10);
    pulse(10);
    poll(8'h12, 8'h80);
    // Locked samples at frame phases 26 and 41 average to 33.5
    rchk(8'h13, 8'h86);
    host.wr(8'h10, 8'h09);
    rchk(8'h12, 8'h00);
    // Disabled: no frame boundary may appear over a full frame
    for (k = 0; k < 70 && frame_start !== 1'b1; k++) @(negedge core_clk);
    check(16'(k), 16'h0046);
    end_sim();
  end
endmodule : sync_fifo_datapath_ctrl_tb_top

`default_nettype wire
